// file: vcic_ctrl.sv
// Virtual CPU interface control, type and maintenance status logic
`timescale 1ns/100ps
`default_nettype none
module vcic_ctrl
  import vcic_pkg::*;
#(
  parameter int unsigned LIST_ENTRIES = 4
) (
  input  wire logic                      mclk,
  input  wire logic                      rst_n,
  input  wire logic [VCIC_AW-1:0]        reg_addr,
  input  wire logic [31:0]               reg_wdata,
  input  wire logic                      reg_wr,
  input  wire logic                      reg_rd,
  output logic      [31:0]               reg_rdata,
  input  wire logic [2*LIST_ENTRIES-1:0] entry_state,
  input  wire logic [LIST_ENTRIES-1:0]   entry_hw,
  input  wire logic [LIST_ENTRIES-1:0]   entry_eoi,
  output logic      [LIST_ENTRIES-1:0]   eoi_status_regs,
  output logic                           hyp_enable,
  output logic      [4:0]                guest_priority_mask_alias,
  output logic      [2:0]                guest_binary_point_alias,
  output logic      [2:0]                guest_group1_binary_point_alias,
  output logic                           guest_eoi_mode_alias,
  output logic                           guest_common_bp_alias,
  output logic                           guest_fiq_enable_alias,
  output logic                           guest_ack_control_alias,
  output logic                           guest_group1_enable_alias,
  output logic                           guest_group0_enable_alias,
  output logic                           virq_allowed,
  output logic                           force_spurious_ack,
  output logic                           maint_irq
);

  localparam logic [5:0] LIST_M1 = 6'(LIST_ENTRIES - 1);
  localparam logic [2:0] ABP_RESET =
    (VCIC_MIN_BP == VCIC_BP_MAX) ? VCIC_BP_MAX : VCIC_MIN_BP + 3'h1;

  logic [7:0]                    hyp_iface_control;
  logic [VCIC_EOICNT_W-1:0]      unmatched_eoi_counter;
  logic [31:0]                   virt_iface_type;
  logic [31:0]                   vm_state_alias_control;
  logic [31:0]                   maint_irq_status;
  logic [LIST_ENTRIES-1:0]       entry_pending;
  logic [LIST_ENTRIES-1:0]       entry_valid;
  logic [6:0]                    valid_count;
  logic                          group1_disabled_cause;
  logic                          group1_enabled_cause;
  logic                          group0_disabled_cause;
  logic                          group0_enabled_cause;
  logic                          no_pending_cause;
  logic                          entry_not_present_cause;
  logic                          underflow_cause;
  logic                          eoi_cause;
  logic                          wr_vmcr;
  logic [31:0]                   next_rdata;

  // Per entry decode of state and EOI request
  genvar gi;
  generate
    for (gi = 0; gi < LIST_ENTRIES; gi++) begin : g_entry
      logic [1:0] st;
      assign st = entry_state[2*gi +: 2];
      assign entry_valid[gi]     = (st != VCIC_ST_INVALID);
      assign entry_pending[gi]   = (st == VCIC_ST_PENDING) ||
                                   (st == VCIC_ST_PEND_ACT);
      assign eoi_status_regs[gi] = (st == VCIC_ST_INVALID) &&
                                   !entry_hw[gi] && entry_eoi[gi];
    end
  endgenerate

  always_comb begin
    valid_count = 7'h00;
    for (int i = 0; i < LIST_ENTRIES; i++) begin
      valid_count = valid_count + {6'h00, entry_valid[i]};
    end
  end

  // Fixed implementation values; no write path exists
  assign virt_iface_type = {VCIC_PRI_BITS_M1,
                            VCIC_PRE_BITS_M1,
                            20'h00000,
                            LIST_M1};

  assign wr_vmcr = reg_wr && (reg_addr == VCIC_OFF_VMCR);

  // Guest alias state, one flop group per field; reserved bits never stored
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      guest_priority_mask_alias <= VCIC_PMASK_RESET;
    end else if (wr_vmcr) begin
      guest_priority_mask_alias <=
        reg_wdata[VCIC_VM_PMASK_LSB +: 5];
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      guest_binary_point_alias <= VCIC_MIN_BP;
    end else if (wr_vmcr) begin
      guest_binary_point_alias <=
        reg_wdata[VCIC_VM_BP_LSB +: 3];
    end
  end

  // Reset value saturates so it never wraps below the plain point
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      guest_group1_binary_point_alias <= ABP_RESET;
    end else if (wr_vmcr) begin
      guest_group1_binary_point_alias <=
        reg_wdata[VCIC_VM_ABP_LSB +: 3];
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      guest_eoi_mode_alias <= 1'b0;
    end else if (wr_vmcr) begin
      guest_eoi_mode_alias <= reg_wdata[VCIC_VM_EOIM_BIT];
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      guest_common_bp_alias <= 1'b0;
    end else if (wr_vmcr) begin
      guest_common_bp_alias <= reg_wdata[VCIC_VM_CBPR_BIT];
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      guest_fiq_enable_alias <= 1'b0;
    end else if (wr_vmcr) begin
      guest_fiq_enable_alias <= reg_wdata[VCIC_VM_FIQ_BIT];
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      guest_ack_control_alias <= 1'b0;
    end else if (wr_vmcr) begin
      guest_ack_control_alias <= reg_wdata[VCIC_VM_ACK_BIT];
    end
  end

  // Group enables also feed the live status causes
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      guest_group1_enable_alias <= 1'b0;
    end else if (wr_vmcr) begin
      guest_group1_enable_alias <= reg_wdata[VCIC_VM_G1EN_BIT];
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      guest_group0_enable_alias <= 1'b0;
    end else if (wr_vmcr) begin
      guest_group0_enable_alias <= reg_wdata[VCIC_VM_G0EN_BIT];
    end
  end

  always_comb begin
    vm_state_alias_control = 32'h00000000;
    vm_state_alias_control[VCIC_VM_PMASK_LSB +: 5] =
      guest_priority_mask_alias;
    vm_state_alias_control[VCIC_VM_BP_LSB +: 3]  = guest_binary_point_alias;
    vm_state_alias_control[VCIC_VM_ABP_LSB +: 3] =
      guest_group1_binary_point_alias;
    vm_state_alias_control[VCIC_VM_EOIM_BIT] = guest_eoi_mode_alias;
    vm_state_alias_control[VCIC_VM_CBPR_BIT] = guest_common_bp_alias;
    vm_state_alias_control[VCIC_VM_FIQ_BIT]  = guest_fiq_enable_alias;
    vm_state_alias_control[VCIC_VM_ACK_BIT]  = guest_ack_control_alias;
    vm_state_alias_control[VCIC_VM_G1EN_BIT] = guest_group1_enable_alias;
    vm_state_alias_control[VCIC_VM_G0EN_BIT] = guest_group0_enable_alias;
  end

  // Hypervisor control enables, kept here so the block is self-contained
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      hyp_iface_control <= VCIC_HCR_RESET;
    end else if (reg_wr && (reg_addr == VCIC_OFF_HCR)) begin
      hyp_iface_control <= reg_wdata[7:0];
    end
  end

  // Counter is software-loaded; the EOI engine is outside this block
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      unmatched_eoi_counter <= '0;
    end else if (reg_wr && (reg_addr == VCIC_OFF_EOICNT)) begin
      unmatched_eoi_counter <= reg_wdata[VCIC_EOICNT_W-1:0];
    end
  end

  assign hyp_enable = hyp_iface_control[VCIC_HCR_EN_BIT];

  // Live causes, recomputed every cycle, never latched
  assign group1_disabled_cause = hyp_iface_control[VCIC_HCR_G1D_BIT] &&
    !guest_group1_enable_alias;
  assign group1_enabled_cause  = hyp_iface_control[VCIC_HCR_G1E_BIT] &&
    guest_group1_enable_alias;
  assign group0_disabled_cause = hyp_iface_control[VCIC_HCR_G0D_BIT] &&
    !guest_group0_enable_alias;
  assign group0_enabled_cause  = hyp_iface_control[VCIC_HCR_G0E_BIT] &&
    guest_group0_enable_alias;
  assign no_pending_cause = hyp_iface_control[VCIC_HCR_NP_BIT] &&
    (entry_pending == '0);
  assign entry_not_present_cause = hyp_iface_control[VCIC_HCR_ENTRY_NOT_PRESENT_CAUSE_BIT] &&
    (unmatched_eoi_counter != '0);
  assign underflow_cause = hyp_iface_control[VCIC_HCR_U_BIT] &&
    (valid_count <= 7'h01);
  assign eoi_cause = |eoi_status_regs;

  assign maint_irq_status = {24'h000000,
    group1_disabled_cause, group1_enabled_cause,
    group0_disabled_cause, group0_enabled_cause,
    no_pending_cause, entry_not_present_cause,
    underflow_cause, eoi_cause};

  // Registered to keep the interrupt line glitch free
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      maint_irq <= 1'b0;
    end else begin
      maint_irq <= hyp_enable &&
        (maint_irq_status != 32'h0);
    end
  end

  assign virq_allowed       = hyp_enable;
  assign force_spurious_ack = !hyp_enable;

  // Read mux; unmapped offsets read zero
  always_comb begin
    case (reg_addr)
      VCIC_OFF_TYPE:   next_rdata = virt_iface_type;
      VCIC_OFF_VMCR:   next_rdata = vm_state_alias_control;
      VCIC_OFF_MISR:   next_rdata = maint_irq_status;
      VCIC_OFF_HCR:    next_rdata = {24'h000000, hyp_iface_control};
      VCIC_OFF_EOICNT:
        next_rdata = {{(32-VCIC_EOICNT_W){1'b0}}, unmatched_eoi_counter};
      default:         next_rdata = 32'h00000000;
    endcase
  end

  // Data stands only in the cycle after the read strobe
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      reg_rdata <= 32'h00000000;
    end else if (reg_rd) begin
      reg_rdata <= next_rdata;
    end else begin
      reg_rdata <= 32'h00000000;
    end
  end

endmodule
`default_nettype wire

// file: vcic_pkg.sv
// Package: register map, field layout and reset values of the vCPU control block
package vcic_pkg;
  localparam int unsigned VCIC_AW = 4;
  // Word offsets chosen for this block; byte address is four times index
  localparam logic [VCIC_AW-1:0] VCIC_OFF_TYPE   = 4'h0;
  localparam logic [VCIC_AW-1:0] VCIC_OFF_VMCR   = 4'h1;
  localparam logic [VCIC_AW-1:0] VCIC_OFF_MISR   = 4'h2;
  localparam logic [VCIC_AW-1:0] VCIC_OFF_HCR    = 4'h3;
  localparam logic [VCIC_AW-1:0] VCIC_OFF_EOICNT = 4'h4;

  // Type register fields
  localparam int unsigned VCIC_TYPE_PRI_LSB = 29;
  localparam int unsigned VCIC_TYPE_PRE_LSB = 26;
  localparam logic [2:0]  VCIC_PRI_BITS_M1  = 3'h4;
  localparam logic [2:0]  VCIC_PRE_BITS_M1  = 3'h4;

  // Control alias fields
  localparam int unsigned VCIC_VM_PMASK_LSB = 27;
  localparam int unsigned VCIC_VM_BP_LSB    = 21;
  localparam int unsigned VCIC_VM_ABP_LSB   = 18;
  localparam int unsigned VCIC_VM_EOIM_BIT  = 9;
  localparam int unsigned VCIC_VM_CBPR_BIT  = 4;
  localparam int unsigned VCIC_VM_FIQ_BIT   = 3;
  localparam int unsigned VCIC_VM_ACK_BIT   = 2;
  localparam int unsigned VCIC_VM_G1EN_BIT  = 1;
  localparam int unsigned VCIC_VM_G0EN_BIT  = 0;

  // Hypervisor control bits (bits 7..0 as in the hypervisor control word)
  localparam int unsigned VCIC_HCR_G1D_BIT  = 7;
  localparam int unsigned VCIC_HCR_G1E_BIT  = 6;
  localparam int unsigned VCIC_HCR_G0D_BIT  = 5;
  localparam int unsigned VCIC_HCR_G0E_BIT  = 4;
  localparam int unsigned VCIC_HCR_NP_BIT   = 3;
  localparam int unsigned VCIC_HCR_ENTRY_NOT_PRESENT_CAUSE_BIT = 2;
  localparam int unsigned VCIC_HCR_U_BIT    = 1;
  localparam int unsigned VCIC_HCR_EN_BIT   = 0;
  localparam logic [7:0]  VCIC_HCR_RESET    = 8'h00;

  // Reset values of aliases, binary point limit and EOI counter width
  localparam logic [4:0]  VCIC_PMASK_RESET  = 5'h00;
  localparam logic [2:0]  VCIC_MIN_BP       = 3'h2;
  localparam logic [2:0]  VCIC_BP_MAX       = 3'h7;
  localparam logic [4:0]  VCIC_EOICNT_W     = 5'h05;

  // List entry state encodings
  localparam logic [1:0]  VCIC_ST_INVALID   = 2'h0;
  localparam logic [1:0]  VCIC_ST_PENDING   = 2'h1;
  localparam logic [1:0]  VCIC_ST_PEND_ACT  = 2'h3;
endpackage

// file: vcic_ctrl_assertions.sv
// Port-level assertions for the vCPU control and status block
`timescale 1ns/100ps
`default_nettype none
module vcic_ctrl_assertions
  import vcic_pkg::*;
#(
  parameter int unsigned LIST_ENTRIES = 4
) (
  input wire logic                      mclk,
  input wire logic                      rst_n,
  input wire logic [VCIC_AW-1:0]        reg_addr,
  input wire logic [31:0]               reg_wdata,
  input wire logic                      reg_wr,
  input wire logic                      reg_rd,
  input wire logic [31:0]               reg_rdata,
  input wire logic [2*LIST_ENTRIES-1:0] entry_state,
  input wire logic [LIST_ENTRIES-1:0]   entry_hw,
  input wire logic [LIST_ENTRIES-1:0]   entry_eoi,
  input wire logic [LIST_ENTRIES-1:0]   eoi_status_regs,
  input wire logic                      hyp_enable,
  input wire logic [2:0]                guest_binary_point_alias,
  input wire logic [2:0]                guest_group1_binary_point_alias,
  input wire logic                      guest_eoi_mode_alias,
  input wire logic                      guest_group1_enable_alias,
  input wire logic                      guest_group0_enable_alias,
  input wire logic                      virq_allowed,
  input wire logic                      force_spurious_ack,
  input wire logic                      maint_irq
);
  logic [LIST_ENTRIES-1:0] exp_eoi;
  logic [31:0]             wd_q;
  logic                    any_q;
  logic                    rd_misr;
  always_comb begin
    for (int i = 0; i < LIST_ENTRIES; i++) begin
      exp_eoi[i] = entry_state[2*i +: 2] == 2'h0 &&
                   !entry_hw[i] && entry_eoi[i];
    end
  end
  // Registered copies so comparisons see the cause, not the later value
  always_ff @(posedge mclk) begin
    wd_q  <= reg_wdata;
    any_q <= |exp_eoi;
  end
  assign rd_misr = reg_rd && reg_addr == VCIC_OFF_MISR;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  a_eoi_status_bits: assert property (eoi_status_regs == exp_eoi)
    else $error("eoi status bits wrong");
  a_type_fixed: assert property (reg_rd && reg_addr == VCIC_OFF_TYPE
    |=> reg_rdata == {3'h4, 3'h4, 20'h0, 6'(LIST_ENTRIES - 1)})
    else $error("type word wrong");
  a_vmcr_write: assert property (reg_wr && reg_addr == VCIC_OFF_VMCR
    |=> {guest_binary_point_alias, guest_group1_binary_point_alias,
         guest_eoi_mode_alias, guest_group1_enable_alias,
         guest_group0_enable_alias} == {wd_q[23:18], wd_q[9], wd_q[1:0]})
    else $error("control alias not written");
  a_bp_reset: assert property ($rose(rst_n) |->
    guest_binary_point_alias == VCIC_MIN_BP &&
    guest_group1_binary_point_alias == VCIC_MIN_BP + 3'h1)
    else $error("binary point reset wrong");
  a_grp1_cause: assert property (rd_misr |=>
    !reg_rdata[{2'h3, $past(guest_group1_enable_alias)}])
    else $error("group1 cause with wrong enable");
  a_grp0_cause: assert property (rd_misr |=>
    !reg_rdata[{2'h2, $past(guest_group0_enable_alias)}])
    else $error("group0 cause with wrong enable");
  a_misr_eoi: assert property (rd_misr |=> reg_rdata[0] == any_q)
    else $error("eoi cause wrong");
  a_misr_reserved: assert property (rd_misr |=>
    reg_rdata[31:8] == 24'h0)
    else $error("status reserved bits set");
  a_maint_on: assert property (hyp_enable && |exp_eoi |=> maint_irq)
    else $error("maintenance output missing");
  a_maint_gated: assert property (!hyp_enable |=> !maint_irq)
    else $error("maintenance while disabled");
  a_virq_gate: assert property (virq_allowed == hyp_enable &&
    force_spurious_ack != hyp_enable)
    else $error("enable gating wrong");
  c_maint: cover property (maint_irq);
  c_misr_read: cover property (rd_misr);
  c_grp1_on: cover property ($rose(guest_group1_enable_alias));
endmodule
`default_nettype wire

// file: tb_top.sv
// Self-checking bench for the vCPU control and status block
`timescale 1ns/100ps
`default_nettype none
module tb_top
  import vcic_pkg::*;
;
  localparam int unsigned LIST_ENTRIES = 4;
  logic                      mclk, rst_n, reg_wr, reg_rd;
  logic [VCIC_AW-1:0]        reg_addr;
  logic [31:0]               reg_wdata, reg_rdata, got, vmcr, e, r;
  logic [2*LIST_ENTRIES-1:0] entry_state;
  logic [LIST_ENTRIES-1:0]   entry_hw, entry_eoi, eoi_status_regs;
  logic                      hyp_enable, virq_allowed, force_spurious_ack;
  logic                      maint_irq;
  logic [4:0]                pmask;
  logic [2:0]                bp, abp;
  logic                      eoim, cbpr, fiq, ack, g1en, g0en;
  logic [7:0]                hcr;
  logic [4:0]                cnt;
  int                        seed = 32'h472C;
  int                        failures = 0, total_checks = 0, cycles = 0;

  vcic_ctrl #(.LIST_ENTRIES(LIST_ENTRIES)) DUT (
    .mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .entry_state(entry_state), .entry_hw(entry_hw), .entry_eoi(entry_eoi),
    .eoi_status_regs(eoi_status_regs), .hyp_enable(hyp_enable),
    .guest_priority_mask_alias(pmask), .guest_binary_point_alias(bp),
    .guest_group1_binary_point_alias(abp), .guest_eoi_mode_alias(eoim),
    .guest_common_bp_alias(cbpr), .guest_fiq_enable_alias(fiq),
    .guest_ack_control_alias(ack), .guest_group1_enable_alias(g1en),
    .guest_group0_enable_alias(g0en), .virq_allowed(virq_allowed),
    .force_spurious_ack(force_spurious_ack), .maint_irq(maint_irq));

  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // Ceiling well above the few hundred cycles the tests need
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      stop_test();
    end
  end
  task automatic check(input logic [31:0] g, input logic [31:0] x);
    total_checks++;
    if (g !== x) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, g, x);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  // Data stands only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge mclk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(negedge mclk);
    d = reg_rdata;
  endtask
  function automatic logic [LIST_ENTRIES-1:0] exp_eoi();
    logic [LIST_ENTRIES-1:0] x = '0;
    for (int i = 0; i < LIST_ENTRIES; i++) begin
      x[i] = entry_state[2*i +: 2] == 2'h0 && !entry_hw[i] && entry_eoi[i];
    end
    return x;
  endfunction
  function automatic logic [31:0] exp_misr(input logic [7:0] h,
                                           input logic [4:0] c,
                                           input logic [31:0] v);
    int   nv = 0;
    logic pend = 1'b0;
    logic eoi = 1'b0;
    for (int i = 0; i < LIST_ENTRIES; i++) begin
      nv += int'(entry_state[2*i +: 2] != 2'h0);
      pend |= entry_state[2*i];
      eoi |= entry_state[2*i +: 2] == 2'h0 && !entry_hw[i] && entry_eoi[i];
    end
    return {24'h0, h[7] & ~v[1], h[6] & v[1], h[5] & ~v[0], h[4] & v[0],
            h[3] & ~pend, h[2] & (c != 5'h00), h[1] & (nv <= 1), eoi};
  endfunction

  initial begin
    {rst_n, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    {entry_state, entry_hw, entry_eoi} = '0;
    repeat (20) @(posedge mclk);
    rst_n <= 1'b1;
    rd(VCIC_OFF_VMCR, got);
    check(got, {8'h0, 3'h2, 3'h3, 18'h0});
    wr(VCIC_OFF_TYPE, 32'hFFFFFFFF);
    rd(VCIC_OFF_TYPE, got);
    check(32'(got[31:29]), 32'h4);
    check(32'(got[28:26]), 32'h4);
    check(32'(got[25:0]), 32'(LIST_ENTRIES - 1));
    wr(4'hF, 32'hFFFFFFFF);
    rd(4'hF, got);
    check(got, 32'h0);
    wr(VCIC_OFF_MISR, 32'hFFFFFFFF);
    $display("test fixed registers done");
    for (int i = 0; i < 40; i++) begin
      r    = $random(seed);
      hcr  = (i < 2) ? 8'hFF : r[23:16];
      cnt  = (i == 0) ? 5'h00 : r[28:24];
      vmcr = $random(seed);
      @(posedge mclk);
      entry_state <= (i == 1) ? 8'h00 : r[7:0];
      entry_hw    <= r[11:8];
      entry_eoi   <= r[15:12];
      wr(VCIC_OFF_HCR, {24'h0, hcr});
      wr(VCIC_OFF_EOICNT, {27'h0, cnt});
      wr(VCIC_OFF_VMCR, vmcr);
      rd(VCIC_OFF_VMCR, got);
      check(got, vmcr & 32'hF8FC021F);
      got = {pmask, 3'h0, bp, abp, 8'h0, eoim, 4'h0,
             cbpr, fiq, ack, g1en, g0en};
      check(got, vmcr & 32'hF8FC021F);
      check(32'(eoi_status_regs), 32'(exp_eoi()));
      rd(VCIC_OFF_MISR, got);
      e = exp_misr(hcr, cnt, vmcr);
      check(32'(got[31:8]), 32'(e[31:8]));
      check(32'(got[7]), 32'(e[7]));
      check(32'(got[6]), 32'(e[6]));
      check(32'(got[5]), 32'(e[5]));
      check(32'(got[4]), 32'(e[4]));
      check(32'(got[3]), 32'(e[3]));
      check(32'(got[2]), 32'(e[2]));
      check(32'(got[1]), 32'(e[1]));
      check(32'(got[0]), 32'(e[0]));
      check({28'h0, maint_irq, hyp_enable, virq_allowed, force_spurious_ack},
            {28'h0, hcr[0] && |e, hcr[0], hcr[0], !hcr[0]});
    end
    $display("test random status done");
    // Reset in mid-run, with random alias state left behind
    @(posedge mclk);
    rst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    rd(VCIC_OFF_VMCR, got);
    check(got, {8'h0, VCIC_MIN_BP, VCIC_MIN_BP + 3'h1, 18'h0});
    got = {pmask, 3'h0, bp, abp, 8'h0, eoim, 4'h0,
           cbpr, fiq, ack, g1en, g0en};
    check(got, {8'h0, VCIC_MIN_BP, VCIC_MIN_BP + 3'h1, 18'h0});
    check(32'(maint_irq), 32'h0);
    $display("test mid-run reset done");
    stop_test();
  end
endmodule
bind vcic_ctrl vcic_ctrl_assertions #(.LIST_ENTRIES(LIST_ENTRIES))
  u_assert (.*);
`default_nettype wire
